// >>> bench/sar_adc_sequencer_tb.sv
`default_nettype none
module sar_adc_sequencer_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic idle_mode = 1'b0;
  logic rc_tick = 1'b0;
  logic [3:0] ev = 4'h0;
  logic [7:0] lat = 8'h20;
  logic [9:0] value = 10'h0C5;
  logic [31:0] prdata;
  logic pready, pslverr, conv_complete, conv_start, sample_hold_acquire;
  logic mux_b_select, scan_step, scan_active, vref_pos_external;
  logic vref_neg_external, rc_clock_enable, converter_interrupt_flag;
  logic [9:0] conv_result;
  logic [15:0] q;
  logic err;
  logic mux_q = 1'b0;
  int n_mismatch = 0;
  int n_checks = 0;
  int n_start = 0, n_cmp = 0, n_scan = 0, n_mux = 0;
  wire charge_time_unit_event = ev[3];
  wire timer5_match = ev[2];
  wire timer3_match = ev[1];
  wire external_interrupt_pin_edge = ev[0];

  sas_sequencer uut (.*);
  sas_core_model core (.*);

  always #2 clk = ~clk;
  always begin
    repeat (4) @(posedge clk);
    rc_tick <= 1'b1;
    @(posedge clk);
    rc_tick <= 1'b0;
  end
  // Non-blocking updates give tasks that read these on an edge a fixed value.
  always @(posedge clk) begin
    n_start <= n_start + int'(conv_start === 1'b1);
    n_cmp <= n_cmp + int'(conv_complete === 1'b1);
    n_scan <= n_scan + int'(scan_step === 1'b1);
    n_mux <= n_mux + int'(mux_b_select !== mux_q);
    mux_q <= mux_b_select;
  end

  task automatic chk(input string n, input logic [15:0] e,
      input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
      input logic [15:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'h0000, d};
    @(posedge clk);
    penable <= 1'b1;
    do
      @(posedge clk);
    while (pready !== 1'b1);
    q = prdata[15:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [11:0] a);
    apb(1'b0, a, 16'h0000);
  endtask

  task automatic wt(ref logic s, input string n, input int lim,
      output int c);
    c = 0;
    while (s !== 1'b1 && c < lim) begin
      @(posedge clk);
      c++;
    end
    chk(n, 16'h0001, {15'h0000, s});
  endtask

  task automatic t_regs();
    logic [1:0] e;
    rd(sas_pkg::CON1_OFF);
    chk("con1 reset", 16'h0000, q);
    wr(sas_pkg::CON2_OFF, 16'hFFFF);
    rd(sas_pkg::CON2_OFF);
    chk("con2 bits", 16'hE43F, q);
    wr(sas_pkg::CON3_OFF, 16'hFFFF);
    rd(sas_pkg::CON3_OFF);
    chk("con3 bits", 16'h9FFF, q);
    rd(12'h0FC);
    chk("unmapped", 16'h0001, {15'h0000, err});
    for (int i = 0; i < 8; i++) begin
      e = (i < 4) ? 2'(i) : 2'b00;
      wr(sas_pkg::CON2_OFF, 16'(i << 13));
      @(posedge clk);
      chk("vref", {14'h0, e},
          {14'h0, vref_neg_external, vref_pos_external});
    end
    wr(sas_pkg::CON3_OFF, 16'h8000);
    wr(sas_pkg::CON1_OFF, 16'h8000);
    @(posedge clk);
    chk("rc on", 16'h0001, {15'h0, rc_clock_enable});
    wr(sas_pkg::CON1_OFF, 16'h0000);
    @(posedge clk);
    chk("rc off", 16'h0000, {15'h0, rc_clock_enable});
  endtask

  task automatic t_formats();
    logic [15:0] fx [4] = '{16'h00C5, 16'hFEC5, 16'h3140, 16'hB140};
    int c;
    wr(sas_pkg::CON3_OFF, 16'h0201);
    wr(sas_pkg::CON2_OFF, 16'h0000);
    for (int f = 0; f < 4; f++) begin
      wr(sas_pkg::CON1_OFF, 16'h80E0 | 16'(f << 8));
      wr(sas_pkg::CON1_OFF, 16'h80E2 | 16'(f << 8));
      wt(conv_complete, "complete", 300, c);
      repeat (2) @(posedge clk);
      rd(sas_pkg::CON1_OFF);
      chk("done and sample", 16'h0001, q & 16'h0003);
      rd(sas_pkg::BUF_OFF);
      chk("format", fx[f], q);
    end
  endtask

  task automatic t_triggers();
    logic [2:0] code [6] = '{3'd6, 3'd4, 3'd2, 3'd1, 3'd0, 3'd7};
    logic [3:0] sel [6] = '{4'h8, 4'h4, 4'h2, 4'h1, 4'h0, 4'h0};
    int s0, c;
    wr(sas_pkg::CON3_OFF, 16'h0803);
    for (int i = 0; i < 6; i++) begin
      // Writing one to the done bit keeps it, so only hardware clears it.
      wr(sas_pkg::CON1_OFF, {8'h80, code[i], 5'h01});
      wr(sas_pkg::CON1_OFF, {8'h80, code[i], 5'h03});
      if (i < 5) begin
        s0 = n_start;
        ev <= ~sel[i];
        @(posedge clk);
        ev <= 4'h0;
        repeat (20) @(posedge clk);
        chk("early start", 16'(s0), 16'(n_start));
        ev <= sel[i];
        if (i == 4)
          wr(sas_pkg::CON1_OFF, 16'h8001);
        @(posedge clk);
        ev <= 4'h0;
      end
      wt(conv_start, "start", 60, c);
      if (i == 5)
        chk("sample time", 16'h1, 16'(c >= 28 && c <= 36));
      rd(sas_pkg::CON1_OFF);
      chk("done cleared", 16'h0000, q & 16'h0001);
      wt(conv_complete, "complete", 100, c);
      repeat (2) @(posedge clk);
    end
  endtask

  task automatic t_auto();
    int m0, s0, x0, c;
    lat <= 8'h00;
    wr(sas_pkg::CON3_OFF, 16'h0100);
    wr(sas_pkg::CON2_OFF, 16'h040B);
    wr(sas_pkg::CON1_OFF, 16'h80E4);
    chk("scan on a", 16'h0001, {15'h0, scan_active});
    chk("irq quiet", 16'h0000, {15'h0, converter_interrupt_flag});
    wr(sas_pkg::CON1_OFF, 16'h80E6);
    wt(converter_interrupt_flag, "irq", 400, c);
    m0 = n_cmp;
    s0 = n_scan;
    x0 = n_mux;
    chk("restart", 16'h0001, {15'h0, sample_hold_acquire});
    chk("mux b next", 16'h0001, {15'h0, mux_b_select});
    chk("scan off on b", 16'h0000, {15'h0, scan_active});
    rd(sas_pkg::CON2_OFF);
    chk("fill half", 16'h0080, q & 16'h0080);
    wt(converter_interrupt_flag, "irq", 400, c);
    chk("group", 16'd3, 16'(n_cmp - m0));
    chk("scan steps", 16'd3, 16'(n_scan - s0));
    chk("mux toggles", 16'd3, 16'(n_mux - x0));
    rd(sas_pkg::BUF_OFF + 12'h020);
    chk("upper half", 16'h00C5, q);
    rd(sas_pkg::BUF_OFF + 12'h00C);
    chk("word three", 16'h0000, q);
    wr(sas_pkg::CON1_OFF, 16'h0000);
    rd(sas_pkg::CON2_OFF);
    chk("off fill", 16'h0000, q & 16'h0080);
    chk("off acquire", 16'h0000, {15'h0, sample_hold_acquire});
  endtask

  task automatic t_idle();
    int s0, c;
    wr(sas_pkg::CON3_OFF, 16'h0803);
    wr(sas_pkg::CON2_OFF, 16'h0000);
    wr(sas_pkg::CON1_OFF, 16'hA0E0);
    wr(sas_pkg::CON1_OFF, 16'hA0E2);
    idle_mode <= 1'b1;
    s0 = n_start;
    repeat (60) @(posedge clk);
    chk("frozen", 16'(s0), 16'(n_start));
    idle_mode <= 1'b0;
    wt(conv_start, "thaw", 60, c);
    wt(conv_complete, "complete", 60, c);
    // A slow system divider means only the RC ticks can start in time.
    wr(sas_pkg::CON3_OFF, 16'h883F);
    wr(sas_pkg::CON1_OFF, 16'h80E0);
    wr(sas_pkg::CON1_OFF, 16'h80E2);
    idle_mode <= 1'b1;
    wt(conv_start, "idle run", 60, c);
    idle_mode <= 1'b0;
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    t_regs();
    t_formats();
    t_triggers();
    t_auto();
    t_idle();
    end_of_test();
  end

  initial begin
    #200000;
    n_mismatch++;
    end_of_test();
  end
endmodule
`default_nettype wire

// >>> bench/sas_core_model.sv
`default_nettype none
module sas_core_model (
  input wire logic clk,
  input wire logic rstn,
  input wire logic conv_start,
  input wire logic [7:0] lat,
  input wire logic [9:0] value,
  output logic conv_complete,
  output logic [9:0] conv_result
);
  logic busy;
  logic [7:0] cnt;

  // The result toggles outside its cycle so a late capture is caught.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      busy <= 1'b0;
      cnt <= 8'h00;
      conv_complete <= 1'b0;
      conv_result <= 10'h000;
    end else begin
      conv_complete <= 1'b0;
      conv_result <= ~conv_result;
      if (conv_start) begin
        busy <= 1'b1;
        cnt <= lat;
      end else if (busy && cnt == 8'h00) begin
        busy <= 1'b0;
        conv_complete <= 1'b1;
        conv_result <= value;
      end else if (busy) begin
        cnt <= cnt - 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// >>> bench/sas_sequencer_assertions.sv
`default_nettype none
module sas_sequencer_chk (
  input wire logic clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic conv_complete,
  input wire logic conv_start,
  input wire logic sample_hold_acquire,
  input wire logic scan_step,
  input wire logic converter_interrupt_flag
);
  logic [5:0] grp_cnt;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  // Counts results since the last interrupt pulse.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn)
      grp_cnt <= 6'h00;
    else if (converter_interrupt_flag)
      grp_cnt <= {5'h00, conv_complete};
    else if (conv_complete)
      grp_cnt <= grp_cnt + 6'h01;
  end

  start_pulse_a: assert property (conv_start |=> !conv_start)
    else $error("conversion start pulse too long");
  start_cause_a: assert property (conv_start |->
      $past(sample_hold_acquire) || $past(sample_hold_acquire, 2))
    else $error("conversion started without sampling");
  start_holds_a: assert property (conv_start |-> !sample_hold_acquire)
    else $error("still acquiring at conversion start");
  // Sampling starts only by auto restart or by a software register write.
  sample_cause_a: assert property ($rose(sample_hold_acquire) |->
      $past(conv_complete) || $past(conv_complete, 2) ||
      $past(psel && penable && pwrite))
    else $error("sampling began without cause");
  irq_pulse_a: assert property (converter_interrupt_flag |=>
      !converter_interrupt_flag)
    else $error("interrupt pulse too long");
  irq_cause_a: assert property (converter_interrupt_flag |->
      $past(conv_complete))
    else $error("interrupt without a stored result");
  scan_cause_a: assert property (scan_step |-> $past(conv_complete))
    else $error("scan step without a stored result");
  group_size_a: assert property (converter_interrupt_flag |->
      grp_cnt >= 6'h01 && grp_cnt <= 6'h10)
    else $error("interrupt group size out of range");

  cover property (converter_interrupt_flag);
  cover property (scan_step);
  cover property (conv_start ##[1:40] conv_complete);
endmodule

bind sas_sequencer sas_sequencer_chk u_chk (.*);
`default_nettype wire

// >>> design/sas_pkg.sv
`default_nettype none
package sas_pkg;
  localparam int unsigned BUF_DEPTH = 16;
  localparam int unsigned RESULT_W = 10;
  localparam int unsigned ADDR_W = 12;
  localparam logic [11:0] CON1_OFF = 12'h000;
  localparam logic [11:0] CON2_OFF = 12'h004;
  localparam logic [11:0] CON3_OFF = 12'h008;
  localparam logic [11:0] BUF_OFF = 12'h040;
  localparam int unsigned C1_ON = 15;
  localparam int unsigned C1_SIDL = 13;
  localparam int unsigned C1_RESULT_FORMAT = 8;
  localparam int unsigned C1_TRIGGER_SOURCE = 5;
  localparam int unsigned C1_AUTO_SAMPLE_START = 2;
  localparam int unsigned C1_SAMPLE_BIT = 1;
  localparam int unsigned C1_DONE = 0;
  localparam int unsigned C2_REFERENCE_SELECT = 13;
  localparam int unsigned C2_SCAN_ENABLE = 10;
  localparam int unsigned C2_FILL_STATUS = 7;
  localparam int unsigned C2_SEQUENCES_PER_INTERRUPT = 2;
  localparam int unsigned C2_BUFFER_MODE = 1;
  localparam int unsigned C2_ALTERNATE_SAMPLING = 0;
  localparam int unsigned C3_CONVERSION_CLOCK_SOURCE = 15;
  localparam int unsigned C3_AUTO_SAMPLE_TIME = 8;
  localparam int unsigned C3_CONVERSION_CLOCK_DIVIDER = 0;
  localparam logic [15:0] CON_RST = 16'h0000;
  localparam logic [7:0] CONVERSION_CLOCK_DIVIDER_MAX = 8'h3F;

  typedef enum logic [1:0] {
    SAS_IDLE = 2'b00,
    SAS_SAMPLE = 2'b01,
    SAS_CONVERT = 2'b10
  } sas_state_t;

  typedef enum logic [2:0] {
    SAS_TRG_SW = 3'b000,
    SAS_TRG_PIN = 3'b001,
    SAS_TRG_TMR3 = 3'b010,
    SAS_TRG_TMR5 = 3'b100,
    SAS_TRG_CHARGE = 3'b110,
    SAS_TRG_AUTO = 3'b111
  } sas_trigger_t;

  typedef enum logic [1:0] {
    SAS_FMT_UINT = 2'b00,
    SAS_FMT_SINT = 2'b01,
    SAS_FMT_UFRAC = 2'b10,
    SAS_FMT_SFRAC = 2'b11
  } sas_format_t;
endpackage
`default_nettype wire

// >>> design/sas_result_format.sv
`default_nettype none
module sas_result_format (
  input wire logic [9:0] raw,
  input wire logic [1:0] result_format,
  output logic [15:0] word
);
  always_comb begin
    case (result_format)
      sas_pkg::SAS_FMT_SFRAC: word = {~raw[9], raw[8:0], 6'h00};
      sas_pkg::SAS_FMT_UFRAC: word = {raw, 6'h00};
      sas_pkg::SAS_FMT_SINT: word = {{7{~raw[9]}}, raw[8:0]};
      sas_pkg::SAS_FMT_UINT: word = {6'h00, raw};
      default: word = {6'h00, raw};
    endcase
  end
endmodule
`default_nettype wire

// >>> design/sas_sequencer.sv
// Summary of operation
// - Results read in one of four formats: signed/unsigned fraction or integer.
// - Trigger field picks what ends sampling: counter, events, pin or software.
// - Auto start resamples right after each conversion; else software starts.
// - Sample bit is 1 while acquiring and 0 while holding.
// - Done bit shows a finished conversion; software may clear it.
// - Turning the module off discards buffer position and fill state.
// - With stop-in-idle set, the sequencer freezes while the chip idles.
// - Reference field selects supply or external positive and negative pins.
// - Scan enable steps multiplexer A through scan channels after each result.
// - Fill status shows which half is being filled in split mode.
// - Interrupt after every field plus one completed sequences.
// - Buffer mode selects two 8-word halves or one 16-word buffer.
// - Alternate sampling uses A first, then B and A in turn.
// - Clock source bit picks the RC oscillator or the system clock.
// - Auto sample time lasts its value in conversion clock periods.
// - Conversion clock period is divider plus one clocks; large codes reserved.
`default_nettype none
module sas_sequencer #(
  parameter int unsigned BUF_DEPTH = sas_pkg::BUF_DEPTH,
  parameter int unsigned ADDR_W = sas_pkg::ADDR_W
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic idle_mode,
  input wire logic rc_tick,
  input wire logic charge_time_unit_event,
  input wire logic timer5_match,
  input wire logic timer3_match,
  input wire logic external_interrupt_pin_edge,
  input wire logic conv_complete,
  input wire logic [9:0] conv_result,
  output logic sample_hold_acquire,
  output logic conv_start,
  output logic mux_b_select,
  output logic scan_step,
  output logic scan_active,
  output logic vref_pos_external,
  output logic vref_neg_external,
  output logic rc_clock_enable,
  output logic converter_interrupt_flag
);
  localparam int unsigned IW = $clog2(BUF_DEPTH);
  localparam logic [11:0] BUF_END =
    sas_pkg::BUF_OFF + 12'(4 * BUF_DEPTH);

  typedef struct packed {
    sas_pkg::sas_state_t st;
    logic module_on;
    logic stop_in_idle;
    logic [1:0] result_format;
    logic [2:0] trigger_source;
    logic auto_sample_start;
    logic sample_bit;
    logic conv_done;
    logic [2:0] reference_select;
    logic scan_enable;
    logic fill_status;
    logic [3:0] sequences_per_interrupt;
    logic buffer_mode;
    logic alternate_sampling;
    logic conversion_clock_source;
    logic [4:0] auto_sample_time;
    logic [7:0] conversion_clock_divider;
    logic [3:0] seq_cnt;
    logic [IW-1:0] wr_ptr;
    logic [4:0] smp_cnt;
    logic mux_b;
    logic start;
    logic irq;
    logic step;
    logic [BUF_DEPTH-1:0][9:0] result_buffer;
    logic [31:0] rdata;
    logic err;
  } sas_regs_t;

  sas_regs_t state_reg;
  sas_regs_t state_next;
  logic tad_tick;
  logic [15:0] con1_word;
  logic [15:0] con2_word;
  logic [15:0] con3_word;
  logic [15:0] buf_word;
  logic [11:0] addr12;
  logic in_buf;
  logic [IW-1:0] rd_idx;
  logic [IW-1:0] wr_idx;
  logic halted;
  logic frozen;
  logic end_sample;
  logic apb_wr;

  assign addr12 = 12'(paddr);
  assign in_buf = (addr12 >= sas_pkg::BUF_OFF) && (addr12 < BUF_END) &&
                  (addr12[1:0] == 2'b00);
  assign rd_idx = IW'((addr12 - sas_pkg::BUF_OFF) >> 2);
  assign apb_wr = psel && penable && pwrite;
  assign halted = !state_reg.module_on;
  assign frozen = state_reg.stop_in_idle && idle_mode;

  // Split mode places the half select above the in-half pointer.
  assign wr_idx = state_reg.buffer_mode ?
    {state_reg.fill_status, state_reg.wr_ptr[IW-2:0]} :
    state_reg.wr_ptr;

  sas_tad_clock u_tad (
    .clk(clk),
    .rstn(rstn),
    .run(state_reg.st == sas_pkg::SAS_SAMPLE),
    .conversion_clock_source(state_reg.conversion_clock_source),
    .rc_tick(rc_tick),
    .conversion_clock_divider(state_reg.conversion_clock_divider),
    .tad_tick(tad_tick)
  );

  sas_result_format u_fmt (
    .raw(state_reg.result_buffer[rd_idx]),
    .result_format(state_reg.result_format),
    .word(buf_word)
  );

  always_comb begin
    con1_word = sas_pkg::CON_RST;
    con1_word[sas_pkg::C1_ON] = state_reg.module_on;
    con1_word[sas_pkg::C1_SIDL] = state_reg.stop_in_idle;
    con1_word[sas_pkg::C1_RESULT_FORMAT +: 2] = state_reg.result_format;
    con1_word[sas_pkg::C1_TRIGGER_SOURCE +: 3] = state_reg.trigger_source;
    con1_word[sas_pkg::C1_AUTO_SAMPLE_START] = state_reg.auto_sample_start;
    con1_word[sas_pkg::C1_SAMPLE_BIT] = state_reg.sample_bit;
    con1_word[sas_pkg::C1_DONE] = state_reg.conv_done;
    con2_word = sas_pkg::CON_RST;
    con2_word[sas_pkg::C2_REFERENCE_SELECT +: 3] = state_reg.reference_select;
    con2_word[sas_pkg::C2_SCAN_ENABLE] = state_reg.scan_enable;
    con2_word[sas_pkg::C2_FILL_STATUS] = state_reg.fill_status;
    con2_word[sas_pkg::C2_SEQUENCES_PER_INTERRUPT +: 4] = state_reg.sequences_per_interrupt;
    con2_word[sas_pkg::C2_BUFFER_MODE] = state_reg.buffer_mode;
    con2_word[sas_pkg::C2_ALTERNATE_SAMPLING] = state_reg.alternate_sampling;
    con3_word = sas_pkg::CON_RST;
    con3_word[sas_pkg::C3_CONVERSION_CLOCK_SOURCE] = state_reg.conversion_clock_source;
    con3_word[sas_pkg::C3_AUTO_SAMPLE_TIME +: 5] = state_reg.auto_sample_time;
    con3_word[sas_pkg::C3_CONVERSION_CLOCK_DIVIDER +: 8] = state_reg.conversion_clock_divider;
  end

  always_comb begin
    case (state_reg.trigger_source)
      sas_pkg::SAS_TRG_AUTO:
        end_sample = (state_reg.smp_cnt >= state_reg.auto_sample_time);
      sas_pkg::SAS_TRG_CHARGE: end_sample = charge_time_unit_event;
      sas_pkg::SAS_TRG_TMR5: end_sample = timer5_match;
      sas_pkg::SAS_TRG_TMR3: end_sample = timer3_match;
      sas_pkg::SAS_TRG_PIN: end_sample = external_interrupt_pin_edge;
      sas_pkg::SAS_TRG_SW: end_sample = !state_next_sample_bit_sw();
      default: end_sample = 1'b0;
    endcase
  end

  // Software view of the sample bit after a write in this cycle.
  function automatic logic state_next_sample_bit_sw();
    logic v;
    v = state_reg.sample_bit;
    if (apb_wr && addr12 == sas_pkg::CON1_OFF) begin
      v = pwdata[sas_pkg::C1_SAMPLE_BIT];
    end
    return v;
  endfunction

  always_comb begin
    state_next = state_reg;
    state_next.start = 1'b0;
    state_next.irq = 1'b0;
    state_next.step = 1'b0;
    state_next.err = 1'b0;
    if (psel && !penable) begin
      state_next.rdata = 32'h0000_0000;
      if (addr12 == sas_pkg::CON1_OFF) begin
        state_next.rdata = {16'h0000, con1_word};
      end else if (addr12 == sas_pkg::CON2_OFF) begin
        state_next.rdata = {16'h0000, con2_word};
      end else if (addr12 == sas_pkg::CON3_OFF) begin
        state_next.rdata = {16'h0000, con3_word};
      end else if (in_buf) begin
        state_next.rdata = {16'h0000, buf_word};
      end else begin
        state_next.err = 1'b1;
      end
    end
    if (apb_wr && addr12 == sas_pkg::CON1_OFF) begin
      state_next.module_on = pwdata[sas_pkg::C1_ON];
      state_next.stop_in_idle = pwdata[sas_pkg::C1_SIDL];
      state_next.result_format = pwdata[sas_pkg::C1_RESULT_FORMAT +: 2];
      state_next.trigger_source = pwdata[sas_pkg::C1_TRIGGER_SOURCE +: 3];
      state_next.auto_sample_start = pwdata[sas_pkg::C1_AUTO_SAMPLE_START];
      state_next.sample_bit = pwdata[sas_pkg::C1_SAMPLE_BIT];
      if (!pwdata[sas_pkg::C1_DONE]) begin
        state_next.conv_done = 1'b0;
      end
    end
    if (apb_wr && addr12 == sas_pkg::CON2_OFF) begin
      state_next.reference_select = pwdata[sas_pkg::C2_REFERENCE_SELECT +: 3];
      state_next.scan_enable = pwdata[sas_pkg::C2_SCAN_ENABLE];
      state_next.sequences_per_interrupt = pwdata[sas_pkg::C2_SEQUENCES_PER_INTERRUPT +: 4];
      state_next.buffer_mode = pwdata[sas_pkg::C2_BUFFER_MODE];
      state_next.alternate_sampling = pwdata[sas_pkg::C2_ALTERNATE_SAMPLING];
    end
    if (apb_wr && addr12 == sas_pkg::CON3_OFF) begin
      state_next.conversion_clock_source = pwdata[sas_pkg::C3_CONVERSION_CLOCK_SOURCE];
      state_next.auto_sample_time = pwdata[sas_pkg::C3_AUTO_SAMPLE_TIME +: 5];
      state_next.conversion_clock_divider = pwdata[sas_pkg::C3_CONVERSION_CLOCK_DIVIDER +: 8];
    end
    // Hardware updates come after the bus write so that hardware wins.
    if (halted) begin
      state_next.st = sas_pkg::SAS_IDLE;
      state_next.sample_bit = 1'b0;
      state_next.seq_cnt = 4'h0;
      state_next.wr_ptr = '0;
      state_next.fill_status = 1'b0;
      state_next.mux_b = 1'b0;
    end else if (!frozen) begin
      case (state_reg.st)
        sas_pkg::SAS_IDLE: begin
          if (state_next.sample_bit) begin
            state_next.st = sas_pkg::SAS_SAMPLE;
            state_next.smp_cnt = 5'h00;
          end
        end
        sas_pkg::SAS_SAMPLE: begin
          if (state_reg.trigger_source != sas_pkg::SAS_TRG_SW) begin
            state_next.sample_bit = 1'b1;
          end
          if (tad_tick && state_reg.smp_cnt != 5'h1F) begin
            state_next.smp_cnt = state_reg.smp_cnt + 5'h01;
          end
          if (end_sample) begin
            state_next.st = sas_pkg::SAS_CONVERT;
            state_next.sample_bit = 1'b0;
            state_next.conv_done = 1'b0;
            state_next.start = 1'b1;
          end
        end
        sas_pkg::SAS_CONVERT: begin
          state_next.sample_bit = 1'b0;
          if (conv_complete) begin
            state_next.result_buffer[wr_idx] = conv_result;
            state_next.conv_done = 1'b1;
            state_next.step = state_reg.scan_enable;
            state_next.mux_b = state_reg.alternate_sampling &&
                               !state_reg.mux_b;
            if (state_reg.seq_cnt >= state_reg.sequences_per_interrupt) begin
              state_next.irq = 1'b1;
              state_next.seq_cnt = 4'h0;
              state_next.wr_ptr = '0;
              state_next.fill_status = state_reg.buffer_mode &&
                                       !state_reg.fill_status;
            end else begin
              state_next.seq_cnt = state_reg.seq_cnt + 4'h1;
              state_next.wr_ptr = state_reg.wr_ptr + IW'(1);
            end
            if (state_reg.auto_sample_start) begin
              state_next.st = sas_pkg::SAS_SAMPLE;
              state_next.sample_bit = 1'b1;
              state_next.smp_cnt = 5'h00;
            end else begin
              state_next.st = sas_pkg::SAS_IDLE;
            end
          end
        end
        default: state_next.st = sas_pkg::SAS_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // Reads are captured in the setup phase, so no wait states are needed.
  assign pready = 1'b1;
  assign prdata = state_reg.rdata;
  assign pslverr = state_reg.err && psel && penable;
  assign sample_hold_acquire = state_reg.sample_bit;
  assign conv_start = state_reg.start;
  assign mux_b_select = state_reg.mux_b;
  assign scan_step = state_reg.step;
  assign scan_active = state_reg.scan_enable && !state_reg.mux_b;
  // Any code with the top bit set falls back to supply and ground.
  assign vref_pos_external = !state_reg.reference_select[2] &&
                             state_reg.reference_select[0];
  assign vref_neg_external = !state_reg.reference_select[2] &&
                             state_reg.reference_select[1];
  assign rc_clock_enable = state_reg.module_on &&
                           state_reg.conversion_clock_source;
  assign converter_interrupt_flag = state_reg.irq;
endmodule
`default_nettype wire

// >>> design/sas_tad_clock.sv
`default_nettype none
module sas_tad_clock (
  input wire logic clk,
  input wire logic rstn,
  input wire logic run,
  input wire logic conversion_clock_source,
  input wire logic rc_tick,
  input wire logic [7:0] conversion_clock_divider,
  output logic tad_tick
);
  typedef struct packed {
    logic [7:0] cnt;
    logic tick;
  } sas_tad_t;

  sas_tad_t tad_reg;
  sas_tad_t tad_next;
  logic [7:0] limit;

  // Reserved divider codes are clamped so the period stays bounded.
  assign limit = (conversion_clock_divider > sas_pkg::CONVERSION_CLOCK_DIVIDER_MAX) ?
                 sas_pkg::CONVERSION_CLOCK_DIVIDER_MAX : conversion_clock_divider;

  always_comb begin
    tad_next = tad_reg;
    tad_next.tick = 1'b0;
    if (!run) begin
      tad_next.cnt = 8'h00;
    end else if (conversion_clock_source) begin
      tad_next.tick = rc_tick;
    end else if (tad_reg.cnt >= limit) begin
      tad_next.cnt = 8'h00;
      tad_next.tick = 1'b1;
    end else begin
      tad_next.cnt = tad_reg.cnt + 8'h01;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tad_reg <= '0;
    end else begin
      tad_reg <= tad_next;
    end
  end

  assign tad_tick = tad_reg.tick;
endmodule
`default_nettype wire
